// [pkg/mcaer_defs.vh]
// constants of the register bank
`ifndef MCAER_DEFS_VH
`define MCAER_DEFS_VH

// register offsets
`define MCAER_ADDR_GEN_CTRL_ALT  16'ha010
`define MCAER_ADDR_LANE_TXDIS    16'ha013
`define MCAER_ADDR_HOST_CTRL     16'ha014
`define MCAER_ADDR_ALARM_EN      16'ha02b
`define MCAER_ADDR_GEN_CTRL      16'hb010
`define MCAER_ADDR_LANE_TXDIS_CO 16'hb013
`define MCAER_ADDR_HOST_CTRL_CO  16'hb014

// reset values
`define MCAER_RST_GEN_CTRL   16'h0000
`define MCAER_RST_LANE_TXDIS 16'h0000
`define MCAER_RST_HOST_CTRL  16'h0000
`define MCAER_RST_ALARM_EN   12'hfff

// writable masks
`define MCAER_ALARM_BITS     12'hfff
`define MCAER_HOST_WR_NORMAL 16'h7ff0
`define MCAER_HOST_WR_CO     16'h77e0
`define MCAER_GEN_KEEP_MASK  16'h7e00

// general control fields
`define MCAER_GC_SOFT_RST   15
`define MCAER_GC_LOW_POWER  14
`define MCAER_GC_TRANSMIT_DISABLE_PIN     13
`define MCAER_GC_PRG3       12
`define MCAER_GC_PRG2       11
`define MCAER_GC_PRG1       10
`define MCAER_GC_ALARM_TEST 9
`define MCAER_GC_PROC_RST   8
`define MCAER_GC_PIN_TXDIS  5
`define MCAER_GC_PIN_LOPWR  4

// host lane control fields
`define MCAER_HC_TX_CHECK   14
`define MCAER_HC_TX_PAT_HI  13
`define MCAER_HC_TX_PAT_LO  11
`define MCAER_HC_LOOPBACK   10
`define MCAER_HC_SQ_LOS     9
`define MCAER_HC_SQ_LOL     8
`define MCAER_HC_RX_GEN     7
`define MCAER_HC_RX_PAT_HI  6
`define MCAER_HC_RX_PAT_LO  4

// polynomial codes on the pattern outputs
`define MCAER_POLY_7   3'h0
`define MCAER_POLY_9   3'h1
`define MCAER_POLY_15  3'h2
`define MCAER_POLY_23  3'h3
`define MCAER_POLY_31  3'h4
`define MCAER_POLY_RSV 3'h7

// self-clearing bits stay set this many clk cycles plus one
`define MCAER_SC_CYCLES 4'hf

// management frame
`define MCAER_PRE_LEN   6'h20
`define MCAER_HDR_LAST  5'h0d
`define MCAER_TA_LAST   5'h01
`define MCAER_DATA_LAST 5'h0f
`define MCAER_OP_ADDR   2'h0
`define MCAER_OP_WRITE  2'h1
`define MCAER_PORT_ADDR 5'h00
`define MCAER_DEV_ADDR  5'h01

`endif

// [design/mcaer_mdio_slave.v]
// management frame receiver and transmitter for the register bank
`include "mcaer_defs.vh"

module mcaer_mdio_slave (
    input  wire        clk,        // system clock
    input  wire        reset_n,    // asynchronous reset, active low
    input  wire        mdc_rise,   // management clock rising edge pulse
    input  wire        mdio_bit,   // synchronised data line
    input  wire [15:0] rd_data,    // read value at reg_addr
    output reg  [15:0] reg_addr,   // current register address
    output reg  [15:0] wr_data,    // data of a write
    output reg         wr_stb,     // one-cycle write strobe
    output reg         mdio_out,   // data line drive value
    output reg         mdio_oe     // data line drive enable
);

    localparam ST_PRE  = 4'h1;
    localparam ST_HDR  = 4'h2;
    localparam ST_TA   = 4'h4;
    localparam ST_DATA = 4'h8;

    reg  [3:0]  state_reg;
    reg  [5:0]  ones_reg;
    reg  [4:0]  cnt_reg;
    reg  [12:0] hdr_reg;
    reg  [15:0] shift_reg;
    reg         match_reg;
    reg  [1:0]  op_reg;
    wire [13:0] hdr_full;
    wire        hdr_match;
    wire        reading;

    assign hdr_full  = {hdr_reg, mdio_bit};
    assign hdr_match = (hdr_full[13:12] == 2'h0) && (hdr_full[9:5] == `MCAER_PORT_ADDR)
                       && (hdr_full[4:0] == `MCAER_DEV_ADDR);
    assign reading   = match_reg & op_reg[1];

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= ST_PRE;
            ones_reg  <= 6'h00;
            cnt_reg   <= 5'h00;
            hdr_reg   <= 13'h0000;
            shift_reg <= 16'h0000;
            match_reg <= 1'b0;
            op_reg    <= 2'h0;
            reg_addr  <= 16'h0000;
            wr_data   <= 16'h0000;
            wr_stb    <= 1'b0;
            mdio_out  <= 1'b0;
            mdio_oe   <= 1'b0;
        end
        else
        begin
            wr_stb <= 1'b0;
            if (mdc_rise)
            begin
                case (state_reg)
                    ST_PRE:
                    begin
                        if (mdio_bit)
                        begin
                            if (ones_reg != `MCAER_PRE_LEN)
                                ones_reg <= ones_reg + 6'h01;
                        end
                        else
                        begin
                            // zero after full preamble starts a frame
                            if (ones_reg == `MCAER_PRE_LEN)
                            begin
                                state_reg <= ST_HDR;
                                hdr_reg   <= 13'h0000;
                                cnt_reg   <= 5'h01;
                            end
                            ones_reg <= 6'h00;
                        end
                    end
                    ST_HDR:
                    begin
                        hdr_reg <= hdr_full[12:0];
                        cnt_reg <= cnt_reg + 5'h01;
                        if (cnt_reg == `MCAER_HDR_LAST)
                        begin
                            match_reg <= hdr_match;
                            op_reg    <= hdr_full[11:10];
                            shift_reg <= rd_data;
                            state_reg <= ST_TA;
                            cnt_reg   <= 5'h00;
                        end
                    end
                    ST_TA:
                    begin
                        cnt_reg <= cnt_reg + 5'h01;
                        if (reading)
                        begin
                            mdio_oe  <= 1'b1;
                            mdio_out <= (cnt_reg == `MCAER_TA_LAST) ? shift_reg[15] : 1'b0;
                            if (cnt_reg == `MCAER_TA_LAST)
                                shift_reg <= {shift_reg[14:0], 1'b0};
                        end
                        if (cnt_reg == `MCAER_TA_LAST)
                        begin
                            state_reg <= ST_DATA;
                            cnt_reg   <= 5'h00;
                        end
                    end
                    ST_DATA:
                    begin
                        cnt_reg <= cnt_reg + 5'h01;
                        if (reading)
                        begin
                            mdio_out  <= shift_reg[15];
                            shift_reg <= {shift_reg[14:0], 1'b0};
                        end
                        else
                            shift_reg <= {shift_reg[14:0], mdio_bit};
                        if (cnt_reg == `MCAER_DATA_LAST)
                        begin
                            state_reg <= ST_PRE;
                            ones_reg  <= 6'h00;
                            mdio_oe   <= 1'b0;
                            mdio_out  <= 1'b0;
                            if (match_reg)
                            begin
                                if (op_reg == `MCAER_OP_ADDR)
                                    reg_addr <= {shift_reg[14:0], mdio_bit};
                                else if (op_reg == `MCAER_OP_WRITE)
                                begin
                                    wr_data <= {shift_reg[14:0], mdio_bit};
                                    wr_stb  <= 1'b1;
                                end
                                else if (!op_reg[0])
                                    reg_addr <= reg_addr + 16'h0001;
                            end
                        end
                    end
                    default:
                        state_reg <= ST_PRE;
                endcase
            end
        end
    end

endmodule

// [design/mcaer_regs.v]
// module control and alarm enable register bank behind the management port
//
// Overview of operation
// - enabled latched alarm bits feed the global alarm.
// - enables of absent features stay zero.
// - alarm enable bits 11..0 used, 15..12 read zero.
// - host bit 14 selects transmit checker mode.
// - coherent two-bit pattern codes give 7, 15, 23, 31.
// - normal three-bit codes give 7, 9, 15, 23, 31; rest reserved.
// - host bit 10 loops host lanes back.
// - host bit 9 squelches lanes on signal loss.
// - host bit 8 squelches lanes on lock loss.
// - host bit 7 enables the receive generator.
// - host control covers all lanes, resets to zero.
// - disable bit n stops network lane n transmit.
// - lane disables cause no state transition.
// - bit 15 one resets module, self-clears; zero ignored.
// - bit 14 requests low power like its pin.
// - bit 13 disables transmit like its pin.
// - bits 12, 11, 10 drive controls three, two, one.
// - bit 9 forces the global alarm as a test.
// - bit 8 resets the processor only, self-clears.
// - bits 5 and 4 read the two pin levels.
// - master enable gates the ORed alarm sources.
`include "mcaer_defs.vh"

module mcaer_regs #(
    parameter [11:0] ALARM_IMPL_MASK = `MCAER_ALARM_BITS  // monitored features present
) (
    input  wire        clk,                         // 100 MHz system clock
    input  wire        reset_n,                     // asynchronous reset, active low
    input  wire        mdc,                         // management clock pin
    input  wire        mdio_in,                     // management data pin, input side
    output wire        mdio_out,                    // management data pin, drive value
    output wire        mdio_oe,                     // management data pin, drive enable
    input  wire        coherent_analog_mode,        // pattern field layout select pin
    input  wire        transmit_disable_pin,        // module transmit disable pin
    input  wire        module_low_power_pin,        // module low power pin
    input  wire [11:0] alarm_latch,                 // latched alarm bits
    input  wire        other_alarm_sources,         // other enable groups ORed
    input  wire        alarm_master_enable,         // master enable of the global alarm
    input  wire [15:0] receive_signal_loss,         // per lane signal loss
    input  wire [15:0] receive_lock_loss,           // per lane lock loss
    input  wire [15:0] host_squelch_request,        // host squelch per lane
    output reg         global_alarm_out,            // global alarm, active high
    output reg         module_reset_out,            // soft module reset request
    output reg         processor_reset_out,         // processor reset request
    output reg         low_power_request,           // low power, soft or pin
    output reg         module_tx_disable,           // transmit disable, soft or pin
    output reg         programmable_control_one,    // soft programmable control one
    output reg         programmable_control_two,    // soft programmable control two
    output reg         programmable_control_three,  // soft programmable control three
    output reg  [15:0] lane_tx_disable_out,         // network lane disables
    output reg         host_tx_checker_en,          // host lanes transmit checker mode
    output reg  [2:0]  host_tx_pattern,             // checker polynomial code
    output reg         host_rx_generator_en,        // host lanes receive generator mode
    output reg  [2:0]  host_rx_pattern,             // generator polynomial code
    output reg         host_loopback,               // host lane loop-back
    output reg  [15:0] host_squelch_out             // per host lane output squelch
);

    reg  [3:0]  sync1_reg;
    reg  [3:0]  sync2_reg;
    reg         mdc_prev_reg;
    reg  [15:0] gen_ctrl_reg;
    reg  [15:0] lane_txdis_reg;
    reg  [15:0] host_ctrl_reg;
    reg  [11:0] alarm_en_reg;
    reg  [3:0]  soft_rst_cnt_reg;
    reg  [3:0]  proc_rst_cnt_reg;
    reg  [15:0] rd_data;
    reg  [15:0] squelch_next;
    wire [15:0] reg_addr;
    wire [15:0] wr_data;
    wire        wr_stb;
    wire        mdc_s;
    wire        mdio_s;
    wire        co_mode_s;
    wire        txdis_pin_s;
    wire        lopwr_pin_s;
    wire        mdc_rise;
    wire        wr_gen;
    wire        wr_txdis;
    wire        wr_host;
    wire        wr_host_co;
    wire        wr_alarm;
    wire        alarm_any;

    // pins pass two flops before use
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sync1_reg    <= 4'h0;
            sync2_reg    <= 4'h0;
            mdc_prev_reg <= 1'b0;
        end
        else
        begin
            sync1_reg    <= {module_low_power_pin, transmit_disable_pin, mdio_in, mdc};
            sync2_reg    <= sync1_reg;
            mdc_prev_reg <= mdc_s;
        end
    end

    assign mdc_s       = sync2_reg[0];
    assign mdio_s      = sync2_reg[1];
    assign txdis_pin_s = sync2_reg[2];
    assign lopwr_pin_s = sync2_reg[3];
    assign mdc_rise    = mdc_s & ~mdc_prev_reg;

    reg co_sync1_reg;
    reg co_sync2_reg;
    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            co_sync1_reg <= 1'b0;
            co_sync2_reg <= 1'b0;
        end
        else
        begin
            co_sync1_reg <= coherent_analog_mode;
            co_sync2_reg <= co_sync1_reg;
        end
    end
    assign co_mode_s = co_sync2_reg;

    mcaer_mdio_slave u_mdio (
        .clk      (clk),
        .reset_n  (reset_n),
        .mdc_rise (mdc_rise),
        .mdio_bit (mdio_s),
        .rd_data  (rd_data),
        .reg_addr (reg_addr),
        .wr_data  (wr_data),
        .wr_stb   (wr_stb),
        .mdio_out (mdio_out),
        .mdio_oe  (mdio_oe)
    );

    // paired offsets share storage
    assign wr_gen     = wr_stb & ((reg_addr == `MCAER_ADDR_GEN_CTRL) |
                                  (reg_addr == `MCAER_ADDR_GEN_CTRL_ALT));
    assign wr_txdis   = wr_stb & ((reg_addr == `MCAER_ADDR_LANE_TXDIS) |
                                  (reg_addr == `MCAER_ADDR_LANE_TXDIS_CO));
    assign wr_host    = wr_stb & (reg_addr == `MCAER_ADDR_HOST_CTRL);
    assign wr_host_co = wr_stb & (reg_addr == `MCAER_ADDR_HOST_CTRL_CO);
    assign wr_alarm   = wr_stb & (reg_addr == `MCAER_ADDR_ALARM_EN);

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            gen_ctrl_reg     <= `MCAER_RST_GEN_CTRL;
            lane_txdis_reg   <= `MCAER_RST_LANE_TXDIS;
            host_ctrl_reg    <= `MCAER_RST_HOST_CTRL;
            alarm_en_reg     <= `MCAER_RST_ALARM_EN & ALARM_IMPL_MASK;
            soft_rst_cnt_reg <= 4'h0;
            proc_rst_cnt_reg <= 4'h0;
        end
        else
        begin
            // self-clearing bits drop after a fixed count
            if (gen_ctrl_reg[`MCAER_GC_SOFT_RST])
                soft_rst_cnt_reg <= soft_rst_cnt_reg + 4'h1;
            if (soft_rst_cnt_reg == `MCAER_SC_CYCLES)
            begin
                gen_ctrl_reg[`MCAER_GC_SOFT_RST] <= 1'b0;
                soft_rst_cnt_reg                 <= 4'h0;
            end
            if (gen_ctrl_reg[`MCAER_GC_PROC_RST])
                proc_rst_cnt_reg <= proc_rst_cnt_reg + 4'h1;
            if (proc_rst_cnt_reg == `MCAER_SC_CYCLES)
            begin
                gen_ctrl_reg[`MCAER_GC_PROC_RST] <= 1'b0;
                proc_rst_cnt_reg                 <= 4'h0;
            end
            if (wr_gen)
            begin
                gen_ctrl_reg[14:9] <= wr_data[14:9];
                // a written one restarts the self-clear
                if (wr_data[`MCAER_GC_SOFT_RST])
                begin
                    gen_ctrl_reg[`MCAER_GC_SOFT_RST] <= 1'b1;
                    soft_rst_cnt_reg                 <= 4'h0;
                end
                if (wr_data[`MCAER_GC_PROC_RST])
                begin
                    gen_ctrl_reg[`MCAER_GC_PROC_RST] <= 1'b1;
                    proc_rst_cnt_reg                 <= 4'h0;
                end
            end
            if (wr_txdis)
                lane_txdis_reg <= wr_data;
            if (wr_host)
                host_ctrl_reg <= wr_data & `MCAER_HOST_WR_NORMAL;
            if (wr_host_co)
                host_ctrl_reg <= wr_data & `MCAER_HOST_WR_CO;
            if (wr_alarm)
                alarm_en_reg <= wr_data[11:0] & ALARM_IMPL_MASK;
        end
    end

    always @*
    begin
        case (reg_addr)
            `MCAER_ADDR_GEN_CTRL, `MCAER_ADDR_GEN_CTRL_ALT:
                rd_data = {gen_ctrl_reg[15:8], 2'h0, txdis_pin_s, lopwr_pin_s, 4'h0};
            `MCAER_ADDR_LANE_TXDIS, `MCAER_ADDR_LANE_TXDIS_CO:
                rd_data = lane_txdis_reg;
            `MCAER_ADDR_HOST_CTRL:
                rd_data = host_ctrl_reg;
            `MCAER_ADDR_HOST_CTRL_CO:
                rd_data = host_ctrl_reg & `MCAER_HOST_WR_CO;
            `MCAER_ADDR_ALARM_EN:
                rd_data = {4'h0, alarm_en_reg};
            default:
                rd_data = 16'h0000;
        endcase
    end

    // pattern decode per mode pin
    function [2:0] poly_code;
        input       co;
        input [2:0] field;
        begin
            if (co)
                case (field[2:1])
                    2'h0:    poly_code = `MCAER_POLY_7;
                    2'h1:    poly_code = `MCAER_POLY_15;
                    2'h2:    poly_code = `MCAER_POLY_23;
                    default: poly_code = `MCAER_POLY_31;
                endcase
            else
                case (field)
                    3'h0:    poly_code = `MCAER_POLY_7;
                    3'h1:    poly_code = `MCAER_POLY_9;
                    3'h2:    poly_code = `MCAER_POLY_15;
                    3'h4:    poly_code = `MCAER_POLY_23;
                    3'h6:    poly_code = `MCAER_POLY_31;
                    default: poly_code = `MCAER_POLY_RSV;
                endcase
        end
    endfunction

    genvar i;
    generate
        for (i = 0; i < 16; i = i + 1)
        begin : g_squelch
            always @*
            begin
                squelch_next[i] = host_squelch_request[i]
                    | (host_ctrl_reg[`MCAER_HC_SQ_LOS] & receive_signal_loss[i])
                    | (host_ctrl_reg[`MCAER_HC_SQ_LOL] & receive_lock_loss[i]);
            end
        end
    endgenerate

    assign alarm_any = (|(alarm_en_reg & alarm_latch)) | other_alarm_sources;

    always @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            global_alarm_out           <= 1'b0;
            module_reset_out           <= 1'b0;
            processor_reset_out        <= 1'b0;
            low_power_request          <= 1'b0;
            module_tx_disable          <= 1'b0;
            programmable_control_one   <= 1'b0;
            programmable_control_two   <= 1'b0;
            programmable_control_three <= 1'b0;
            lane_tx_disable_out        <= 16'h0000;
            host_tx_checker_en         <= 1'b0;
            host_tx_pattern            <= `MCAER_POLY_7;
            host_rx_generator_en       <= 1'b0;
            host_rx_pattern            <= `MCAER_POLY_7;
            host_loopback              <= 1'b0;
            host_squelch_out           <= 16'h0000;
        end
        else
        begin
            global_alarm_out <= (alarm_master_enable & alarm_any)
                                | gen_ctrl_reg[`MCAER_GC_ALARM_TEST];
            module_reset_out    <= gen_ctrl_reg[`MCAER_GC_SOFT_RST];
            processor_reset_out <= gen_ctrl_reg[`MCAER_GC_PROC_RST];
            low_power_request   <= gen_ctrl_reg[`MCAER_GC_LOW_POWER] | lopwr_pin_s;
            module_tx_disable   <= gen_ctrl_reg[`MCAER_GC_TRANSMIT_DISABLE_PIN] | txdis_pin_s;
            programmable_control_one   <= gen_ctrl_reg[`MCAER_GC_PRG1];
            programmable_control_two   <= gen_ctrl_reg[`MCAER_GC_PRG2];
            programmable_control_three <= gen_ctrl_reg[`MCAER_GC_PRG3];
            // no state event raised
            lane_tx_disable_out  <= lane_txdis_reg;
            host_tx_checker_en   <= host_ctrl_reg[`MCAER_HC_TX_CHECK];
            host_tx_pattern      <= poly_code(co_mode_s,
                host_ctrl_reg[`MCAER_HC_TX_PAT_HI:`MCAER_HC_TX_PAT_LO]);
            host_rx_generator_en <= host_ctrl_reg[`MCAER_HC_RX_GEN];
            host_rx_pattern      <= poly_code(co_mode_s,
                host_ctrl_reg[`MCAER_HC_RX_PAT_HI:`MCAER_HC_RX_PAT_LO]);
            host_loopback        <= host_ctrl_reg[`MCAER_HC_LOOPBACK];
            host_squelch_out     <= squelch_next;
        end
    end

endmodule

// [sim/mcaer_regs_properties.sv]
// concurrent checks on the register bank outputs
module mcaer_regs_properties (
    input logic       clk,                  // system clock
    input logic       reset_n,              // reset, active low
    input logic       module_low_power_pin, // low power pin
    input logic       low_power_request,    // low power out
    input logic       alarm_master_enable,  // alarm master enable
    input logic       other_alarm_sources,  // other alarm terms
    input logic       global_alarm_out,     // global alarm
    input logic       module_reset_out,     // soft module reset
    input logic       processor_reset_out,  // processor reset
    input logic [2:0] host_tx_pattern,      // checker code
    input logic [2:0] host_rx_pattern       // generator code
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    a_alarm_other: assert property (alarm_master_enable && other_alarm_sources |=> global_alarm_out)
        else $error("alarm not raised");
    a_lowpower_pin: assert property (module_low_power_pin [*4] |=> low_power_request)
        else $error("low power pin ignored");
    a_reset_hold: assert property ($rose(module_reset_out) |=> module_reset_out [*8])
        else $error("module reset too short");
    a_reset_ends: assert property ($rose(module_reset_out) |-> ##[8:20] !module_reset_out)
        else $error("module reset stuck");
    a_proc_hold: assert property ($rose(processor_reset_out) |=> processor_reset_out [*8])
        else $error("processor reset too short");
    a_proc_ends: assert property ($rose(processor_reset_out) |-> ##[8:20] !processor_reset_out)
        else $error("processor reset stuck");
    a_tx_code: assert property (!(host_tx_pattern inside {3'h5, 3'h6}))
        else $error("bad tx code");
    a_rx_code: assert property (!(host_rx_pattern inside {3'h5, 3'h6}))
        else $error("bad rx code");
endmodule

// [sim/mcaer_mdio_host.sv]
// management bus master model
module mcaer_mdio_host (
    output logic mdc,      // management clock, still between frames
    output wire  mdio_in,  // resolved data line
    input  wire  mdio_out, // device drive value
    input  wire  mdio_oe   // device drive enable
);
    timeunit 1ns;
    timeprecision 1ps;
    logic drv_en = 1'b0;
    logic drv_val = 1'b1;
    initial mdc = 1'b0;
    // pull-up holds the line high when nobody drives
    assign mdio_in = mdio_oe ? mdio_out : (drv_en ? drv_val : 1'b1);
    task automatic tick(logic b);
        drv_val = b;
        #80 mdc = 1'b1;
        #80 mdc = 1'b0;
    endtask
    task automatic frame(logic [1:0] op, logic [15:0] d, output logic [15:0] q);
        logic [13:0] hdr;
        hdr = {2'h0, op, 5'h00, 5'h01};
        #3 drv_en = 1'b1;
        repeat (32) tick(1'b1);
        for (int i = 13; i >= 0; i--) tick(hdr[i]);
        if (op[1])
        begin
            drv_en = 1'b0;
            repeat (2) tick(1'b1);
            for (int i = 15; i >= 0; i--)
            begin
                #80 q[i] = mdio_in;
                mdc = 1'b1;
                #80 mdc = 1'b0;
            end
        end
        else
        begin
            tick(1'b1);
            tick(1'b0);
            for (int i = 15; i >= 0; i--) tick(d[i]);
        end
        drv_en = 1'b0;
    endtask
endmodule

// [sim/tb_mcaer_regs.sv]
// self-checking bench of the register bank
module tb_mcaer_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, reset_n = 1'b0, coherent_analog_mode, transmit_disable_pin;
    logic module_low_power_pin, other_alarm_sources, alarm_master_enable;
    logic [11:0] alarm_latch;
    logic [15:0] receive_signal_loss, receive_lock_loss, host_squelch_request, q, e, s;
    wire mdc, mdio_in, mdio_out, mdio_oe, global_alarm_out, module_reset_out;
    wire processor_reset_out, low_power_request, module_tx_disable, host_loopback;
    wire host_tx_checker_en, host_rx_generator_en, programmable_control_one;
    wire programmable_control_two, programmable_control_three;
    wire [15:0] lane_tx_disable_out, host_squelch_out;
    wire [2:0] host_tx_pattern, host_rx_pattern;
    wire [7:0] ctl = {low_power_request, module_tx_disable, programmable_control_one,
        programmable_control_two, programmable_control_three, global_alarm_out,
        module_reset_out, processor_reset_out};
    logic [2:0] c, nt [8] = '{3'h0, 3'h1, 3'h2, 3'h7, 3'h3, 3'h7, 3'h4, 3'h7};
    logic [2:0] ct [4] = '{3'h0, 3'h2, 3'h3, 3'h4};
    logic [15:0] eq [$], ad [8] = '{16'ha010, 16'ha013, 16'ha014, 16'ha02b, 16'hb010,
        16'hb013, 16'hb014, 16'ha020};
    string nq [$], n;
    logic [31:0] r = 32'hb3bd;
    int n_fail = 0, tests_run = 0;
    event got;
    mcaer_regs #(.ALARM_IMPL_MASK(12'hffe)) uut (.*);
    mcaer_mdio_host host (.*);
    always #5 clk = ~clk;
    function automatic logic [31:0] xs();
        r ^= r << 13;
        r ^= r >> 17;
        r ^= r << 5;
        return r;
    endfunction
    task automatic chk(string nm, logic [15:0] ex, logic [15:0] v);
        nq.push_back(nm);
        eq.push_back(ex);
        s = v;
        ->got;
        #1;
    endtask
    always @(got)
    begin
        n = nq.pop_front();
        e = eq.pop_front();
        tests_run++;
        if (s !== e)
        begin
            $display("ERROR %s expected %h seen %h", n, e, s);
            n_fail++;
        end
    end
    task automatic wr(logic [15:0] a, logic [15:0] d);
        host.frame(2'h0, a, q);
        host.frame(2'h1, d, q);
        repeat (4) @(negedge clk);
    endtask
    task automatic rd(logic [15:0] a, logic [15:0] ex);
        host.frame(2'h0, a, q);
        host.frame(2'h3, 16'h0000, q);
        chk($sformatf("reg %h", a), ex, q);
    endtask
    task automatic al(logic [13:0] v, logic x);
        @(negedge clk);
        {alarm_latch, alarm_master_enable, other_alarm_sources} = v;
        repeat (2) @(negedge clk);
        chk("alarm", {15'h0, x}, {15'h0, global_alarm_out});
    endtask
    task automatic sq(logic au);
        @(negedge clk);
        {receive_signal_loss, receive_lock_loss} = xs();
        host_squelch_request = r[31:16] ^ r[15:0];
        repeat (2) @(negedge clk);
        chk("squelch", host_squelch_request | {16{au}} & (r[31:16] | r[15:0]), host_squelch_out);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        #800us;
        n_fail++;
        conclude();
    end
    initial
    begin
        {coherent_analog_mode, transmit_disable_pin, module_low_power_pin} = 3'h0;
        {alarm_latch, alarm_master_enable, other_alarm_sources} = 14'h0000;
        {receive_signal_loss, receive_lock_loss, host_squelch_request} = 48'h0;
        repeat (16) @(negedge clk);
        reset_n = 1'b1;
        foreach (ad[i]) rd(ad[i], (i == 3) ? 16'h0ffe : 16'h0000);
        $display("reset values done");
        wr(16'ha02b, 16'hffff);
        rd(16'ha02b, 16'h0ffe);
        al({12'h000, 2'h3}, 1'b1);
        al({12'h801, 2'h2}, 1'b1);
        al({12'h001, 2'h2}, 1'b0);
        al({12'h801, 2'h1}, 1'b0);
        wr(16'ha014, 16'hffff);
        rd(16'hb014, 16'h77e0);
        chk("host", 16'h0007, {13'h0, host_tx_checker_en, host_rx_generator_en, host_loopback});
        repeat (8) sq(1'b1);
        $display("alarm and host control done");
        for (int i = 0; i < 12; i++)
        begin
            c = i[2:0];
            coherent_analog_mode = (i > 7);
            wr(16'ha014, (i > 7) ? {2'h0, c[1:0], 5'h0, ~c[1:0], 5'h0} : {2'h0, c, 4'h0, ~c, 4'h0});
            chk("pattern", (i > 7) ? {10'h0, ct[c[1:0]], ct[~c[1:0]]} : {10'h0, nt[c], nt[~c]},
                {10'h0, host_tx_pattern, host_rx_pattern});
        end
        repeat (4) sq(1'b0);
        wr(16'hb010, 16'hffff);
        chk("control", 16'h00ff, {8'h0, ctl});
        {transmit_disable_pin, module_low_power_pin} = 2'h3;
        rd(16'ha010, 16'h7e30);
        wr(16'ha010, 16'h0000);
        chk("control", 16'h00c0, {8'h0, ctl});
        void'(xs());
        wr(16'hb013, r[15:0]);
        rd(16'ha013, r[15:0]);
        chk("lane", r[15:0], lane_tx_disable_out);
        $display("control and lane done");
        conclude();
    end
endmodule
bind mcaer_regs mcaer_regs_properties chk (.*);
